//--- logic/nfc_pkg.sv
package nfc_pkg;
    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_READ_A = 8'h00;
    localparam logic [7:0] CMD_READ_B = 8'h01;
    localparam logic [7:0] CMD_READ_SPARE = 8'h50;
    localparam logic [7:0] CMD_READ_IDENTIFICATION_CMD = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
    localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int PAGE_COUNT = 32768;
    localparam int PAGE_BYTES = 528;
    localparam int SPARE_START = 512;
    localparam int SPARE_LAST = 527;
    localparam int BLOCK_PAGES = 32;
    localparam int BLOCK_COUNT = 1024;
    localparam int VALID_BLOCKS_MIN = 1004;
    localparam int ADDR_BITS = 24;
    localparam logic [1:0] ADDR_CYCLES_PAGE = 2'd3;
    localparam logic [1:0] ADDR_CYCLES_BLOCK = 2'd2;
    localparam logic [9:0] LEN_ZERO = 10'h000;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 40;
    localparam int STROBE_LOW_NS = 50;
    localparam int STROBE_HIGH_NS = 50;
    localparam int WHR_NS = 60;
    localparam logic [3:0] STROBE_LOW_CYC =
        4'((STROBE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] STROBE_HIGH_CYC =
        4'((STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WHR_CYC = 4'((WHR_NS + CLK_NS - 1) / CLK_NS);
    // ----------------------------------------
    // operations and carriers
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'd0,
        OP_READ_SPARE = 3'd1,
        OP_READ_IDENTIFICATION_CMD = 3'd2,
        OP_STATUS = 3'd3,
        OP_PROGRAM = 3'd4,
        OP_ERASE = 3'd5,
        OP_RESET = 3'd6
    } nfc_op_type;

    typedef struct packed {
        nfc_op_type op;
        logic half_b;
        logic [23:0] addr;
        logic [9:0] len;
    } nfc_req_type;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
    } nfc_ctl_type;
endpackage

//--- logic/nfc_host.sv
`timescale 1ns/100ps
// How it works
// RULE_01: target has 32768 pages of 528 columns
// RULE_02: columns 512..527 are spare area
// RULE_03: device buffers one 528-byte page
// RULE_04: 1024 blocks of 32 pages each
// RULE_05: only whole-page and whole-block operations
// RULE_06: commands, addresses, data share eight lines
// RULE_07: byte written by write strobe pulse low
// RULE_08: latch strobes mark command or address
// RULE_09: program is 80h setup then 10h confirm
// RULE_10: erase is 60h setup then D0h confirm
// RULE_11: address bytes: column, low row, high row
// RULE_12: three address cycles, erase only two rows
// RULE_13: device decodes 50h, 90h, 70h
// RULE_14: 00h first half, 01h second half
// RULE_15: only FFh and 70h taken while busy
// RULE_16: host issues only defined command codes
// RULE_17: command and address strobe combinations
// RULE_18: write protect high for writes
// RULE_19: at least 1004 valid blocks, block 0 good
// RULE_20: host never touches factory bad blocks
// RULE_21: ready/busy low while device works
// RULE_22: read strobe fall advances column counter
// RULE_23: extra address cycles ignored by device
// RULE_24: host waits for ready before commands
module nfc_host
    import nfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // request port
    input wire logic req_valid_in,
    input wire nfc_req_type req_in,
    output logic req_ready_out,
    // write data stream
    input wire logic wdata_valid_in,
    input wire logic [7:0] wdata_in,
    output logic wdata_ready_out,
    // read data stream
    output logic rdata_valid_out,
    output logic [7:0] rdata_out,
    output logic done_out,
    // flash pins
    output nfc_ctl_type flash_ctl_out,
    output logic [7:0] flash_io_out,
    output logic flash_io_oe_n_out,
    input wire logic [7:0] flash_io_in,
    input wire logic flash_ready_in
);
    typedef enum logic [8:0] {
        ST_IDLE = 9'b000000001,
        ST_WAIT = 9'b000000010,
        ST_PTR = 9'b000000100,
        ST_CMD = 9'b000001000,
        ST_ADDR = 9'b000010000,
        ST_WDATA = 9'b000100000,
        ST_CONF = 9'b001000000,
        ST_BUSY = 9'b010000000,
        ST_RDATA = 9'b100000000
    } nfc_state_type;

    // ----------------------------------------
    // ready input synchroniser
    // ----------------------------------------
    logic [2:0] rdy_sync;
    logic rdy;
    logic [2:0] next_rdy_sync;
    logic next_rdy;

    always_comb begin
        next_rdy_sync = {rdy_sync[1:0], flash_ready_in};
        next_rdy = rdy;
        if (rdy_sync[2] == rdy_sync[1]) begin
            next_rdy = rdy_sync[2]; // [RULE_21]
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdy_sync <= 3'b000;
            rdy <= 1'b0;
        end else begin
            rdy_sync <= next_rdy_sync;
            rdy <= next_rdy;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    nfc_state_type state, next_state;
    nfc_req_type cur, next_cur;
    nfc_ctl_type ctl, next_ctl;
    logic [7:0] io_out, next_io_out;
    logic io_oe_n, next_io_oe_n;
    logic [3:0] tmr, next_tmr;
    logic phase, next_phase;
    logic [1:0] acnt, next_acnt;
    logic [9:0] cnt, next_cnt;
    logic req_ready, next_req_ready;
    logic wd_ready, next_wd_ready;
    logic rd_valid, next_rd_valid;
    logic [7:0] rd_data, next_rd_data;
    logic done, next_done;
    logic [1:0] addr_need;
    logic [7:0] addr_byte;
    logic [7:0] cmd_code;
    logic [7:0] ptr_code;

    always_comb begin
        // erase sends only the two row bytes
        if (cur.op == OP_ERASE) begin
            addr_need = ADDR_CYCLES_BLOCK; // [RULE_12]
        end else begin
            addr_need = ADDR_CYCLES_PAGE; // [RULE_12]
        end
        unique case (acnt)
            2'd0: addr_byte = (cur.op == OP_ERASE) ? cur.addr[15:8]
                                                   : cur.addr[7:0];
            2'd1: addr_byte = (cur.op == OP_ERASE) ? cur.addr[23:16]
                                                   : cur.addr[15:8];
            default: addr_byte = cur.addr[23:16]; // [RULE_11]
        endcase
        unique case (cur.op)
            OP_READ: cmd_code = cur.half_b ? CMD_READ_B : CMD_READ_A;
            OP_READ_SPARE: cmd_code = CMD_READ_SPARE; // [RULE_13]
            OP_READ_IDENTIFICATION_CMD: cmd_code = CMD_READ_IDENTIFICATION_CMD;
            OP_STATUS: cmd_code = CMD_STATUS;
            OP_PROGRAM: cmd_code = CMD_PROG_SETUP; // [RULE_09]
            OP_ERASE: cmd_code = CMD_ERASE_SETUP; // [RULE_10]
            default: cmd_code = CMD_RESET; // [RULE_16]
        endcase
        // program sets the pointer first; 01h holds for one operation
        ptr_code = cur.half_b ? CMD_READ_B : CMD_READ_A; // [RULE_14]
    end

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_ctl = ctl;
        next_io_out = io_out;
        next_io_oe_n = io_oe_n;
        next_tmr = tmr;
        next_phase = phase;
        next_acnt = acnt;
        next_cnt = cnt;
        next_req_ready = 1'b0;
        next_wd_ready = 1'b0;
        next_rd_valid = 1'b0;
        next_rd_data = rd_data;
        next_done = 1'b0;
        next_ctl.wp_n = 1'b1; // [RULE_18]
        if (tmr != 4'd0) begin
            next_tmr = tmr - 4'd1;
        end
        unique case (state)
            ST_IDLE: begin
                next_req_ready = 1'b1;
                next_ctl.ce_n = 1'b1;
                next_io_oe_n = 1'b1;
                if (req_valid_in && req_ready) begin
                    next_req_ready = 1'b0;
                    // requester keeps bad blocks out of requests
                    next_cur = req_in; // [RULE_20]
                    next_ctl.ce_n = 1'b0;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // only reset and status may go while busy
                if (rdy || cur.op == OP_RESET || cur.op == OP_STATUS) begin
                    next_phase = 1'b0; // [RULE_24] [RULE_15]
                    next_state = (cur.op == OP_PROGRAM) ? ST_PTR : ST_CMD;
                end
            end
            ST_PTR, ST_CMD, ST_ADDR, ST_CONF, ST_WDATA: begin
                if (tmr == 4'd0 && !phase) begin
                    if (state != ST_WDATA || wdata_valid_in) begin
                        // drive byte and pull write strobe low
                        next_ctl.cle = (state != ST_ADDR)
                                     && (state != ST_WDATA); // [RULE_08]
                        next_ctl.ale = (state == ST_ADDR); // [RULE_17]
                        next_ctl.we_n = 1'b0; // [RULE_07]
                        next_io_oe_n = 1'b0; // [RULE_06]
                        next_wd_ready = (state == ST_WDATA);
                        unique case (state)
                            ST_PTR: next_io_out = ptr_code;
                            ST_CMD: next_io_out = cmd_code;
                            ST_ADDR: next_io_out = addr_byte;
                            ST_CONF: next_io_out = (cur.op == OP_ERASE)
                                ? CMD_ERASE_CONFIRM : CMD_PROG_CONFIRM;
                            default: next_io_out = wdata_in;
                        endcase
                        next_tmr = STROBE_LOW_CYC;
                        next_phase = 1'b1;
                    end
                end else if (tmr == 4'd0 && phase) begin
                    // rising edge latches the byte
                    next_ctl.we_n = 1'b1; // [RULE_07]
                    next_tmr = STROBE_HIGH_CYC;
                    next_phase = 1'b0;
                    next_acnt = 2'd0;
                    unique case (state)
                        ST_PTR: next_state = ST_CMD;
                        ST_CMD: begin
                            if (cur.op == OP_STATUS || cur.op == OP_READ_IDENTIFICATION_CMD
                                || cur.op == OP_RESET) begin
                                next_state = (cur.op == OP_RESET)
                                    ? ST_BUSY : ST_RDATA;
                                next_tmr = WHR_CYC;
                            end else begin
                                next_state = ST_ADDR;
                            end
                            next_cnt = cur.len;
                        end
                        ST_ADDR: begin
                            next_acnt = acnt + 2'd1;
                            if (acnt + 2'd1 == addr_need) begin // [RULE_23]
                                next_state = (cur.op == OP_PROGRAM)
                                    ? ST_WDATA
                                    : (cur.op == OP_ERASE) ? ST_CONF
                                    : ST_BUSY;
                                if (cur.op == OP_PROGRAM && cur.len == LEN_ZERO)
                                    begin
                                    next_state = ST_CONF;
                                end
                            end else begin
                                next_state = ST_ADDR;
                            end
                        end
                        ST_WDATA: begin
                            next_cnt = cnt - 10'd1;
                            if (cnt == 10'd1) begin
                                next_state = ST_CONF; // [RULE_05]
                            end
                        end
                        default: next_state = ST_BUSY; // [RULE_10]
                    endcase
                end
            end
            ST_BUSY: begin
                // wait out busy low window, then ready high
                // latch strobes held past the write strobe rise
                next_ctl.cle = 1'b0; // [RULE_08]
                next_ctl.ale = 1'b0; // [RULE_08]
                next_io_oe_n = 1'b1;
                if (tmr == 4'd0 && !phase) begin
                    next_tmr = WHR_CYC;
                    next_phase = 1'b1;
                end else if (tmr == 4'd0 && phase && rdy) begin // [RULE_21]
                    next_phase = 1'b0;
                    if (cur.op == OP_READ || cur.op == OP_READ_SPARE) begin
                        next_state = ST_RDATA;
                    end else begin
                        next_done = 1'b1;
                        next_ctl.ce_n = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_RDATA: begin
                next_ctl.cle = 1'b0; // [RULE_08]
                next_ctl.ale = 1'b0; // [RULE_08]
                next_io_oe_n = 1'b1;
                if (cnt == LEN_ZERO && !phase && tmr == 4'd0) begin
                    next_done = 1'b1;
                    next_ctl.ce_n = 1'b1;
                    next_state = ST_IDLE;
                end else if (tmr == 4'd0 && !phase) begin
                    next_ctl.read_strobe_n = 1'b0; // [RULE_22]
                    next_tmr = STROBE_LOW_CYC;
                    next_phase = 1'b1;
                end else if (tmr == 4'd0 && phase) begin
                    next_ctl.read_strobe_n = 1'b1;
                    next_rd_valid = 1'b1;
                    next_rd_data = flash_io_in;
                    next_cnt = cnt - 10'd1;
                    next_tmr = STROBE_HIGH_CYC;
                    next_phase = 1'b0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            cur <= '0;
            ctl <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                     read_strobe_n: 1'b1, wp_n: 1'b0};
            io_out <= 8'h00;
            io_oe_n <= 1'b1;
            tmr <= 4'd0;
            phase <= 1'b0;
            acnt <= 2'd0;
            cnt <= LEN_ZERO;
            req_ready <= 1'b0;
            wd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            ctl <= next_ctl;
            io_out <= next_io_out;
            io_oe_n <= next_io_oe_n;
            tmr <= next_tmr;
            phase <= next_phase;
            acnt <= next_acnt;
            cnt <= next_cnt;
            req_ready <= next_req_ready;
            wd_ready <= next_wd_ready;
            rd_valid <= next_rd_valid;
            rd_data <= next_rd_data;
            done <= next_done;
        end
    end

    assign req_ready_out = req_ready;
    assign wdata_ready_out = wd_ready;
    assign rdata_valid_out = rd_valid;
    assign rdata_out = rd_data;
    assign done_out = done;
    assign flash_ctl_out = ctl;
    assign flash_io_out = io_out;
    assign flash_io_oe_n_out = io_oe_n;
endmodule

//--- dv/nfc_host_monitor.sv
`timescale 1ns/100ps
module nfc_host_monitor
    import nfc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // watched ports
    input wire logic rdata_valid_out,
    input wire nfc_ctl_type flash_ctl_out,
    input wire logic [7:0] flash_io_out,
    input wire logic flash_io_oe_n_out,
    input wire logic flash_ready_in
);
    // ----------------------------------------
    // pin protocol checks
    // ----------------------------------------
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    logic wr, cmd_wr;
    assign wr = !flash_ctl_out.we_n;
    assign cmd_wr = wr && flash_ctl_out.cle;
    property p_we_pulse;
        $fell(flash_ctl_out.we_n) |-> wr [*3] ##1 !wr [*3];
    endproperty
    a_we_pulse: assert property (p_we_pulse)
        else $error("write strobe pulse shape wrong");
    property p_select;
        (wr || !flash_ctl_out.read_strobe_n) |-> !flash_ctl_out.ce_n;
    endproperty
    a_select: assert property (p_select)
        else $error("strobe without chip select");
    property p_latch_excl;
        flash_ctl_out.cle |-> !flash_ctl_out.ale;
    endproperty
    a_latch_excl: assert property (p_latch_excl)
        else $error("both latch strobes high");
    property p_bus_drive;
        wr |-> !flash_io_oe_n_out && flash_ctl_out.read_strobe_n;
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("bus not driven during write");
    property p_wp_high;
        wr |-> flash_ctl_out.wp_n;
    endproperty
    a_wp_high: assert property (p_wp_high)
        else $error("write protect low during write");
    property p_read_mode;
        !flash_ctl_out.read_strobe_n |-> !flash_ctl_out.cle &&
            !flash_ctl_out.ale && !wr && flash_io_oe_n_out;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("bad pin state during data output");
    property p_cmd_set;
        $fell(flash_ctl_out.we_n) && flash_ctl_out.cle |-> flash_io_out
            inside {8'h00, 8'h01, 8'h50, 8'h90, 8'hFF, 8'h80, 8'h10,
            8'h60, 8'hD0, 8'h70};
    endproperty
    a_cmd_set: assert property (p_cmd_set)
        else $error("undefined command code");
    property p_wait_ready;
        $fell(flash_ctl_out.we_n) && flash_ctl_out.cle &&
            !(flash_io_out inside {8'hFF, 8'h70}) |->
            flash_ready_in && $past(flash_ready_in, 3);
    endproperty
    a_wait_ready: assert property (p_wait_ready)
        else $error("command while device busy");
    property p_rd_pulse;
        $fell(flash_ctl_out.read_strobe_n) |->
            !flash_ctl_out.read_strobe_n [*3] ##1 flash_ctl_out.read_strobe_n;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe pulse shape wrong");
    c_prog: cover property (cmd_wr && flash_io_out == 8'h10);
    c_erase: cover property (cmd_wr && flash_io_out == 8'hD0);
    c_read: cover property (rdata_valid_out);
endmodule
bind nfc_host nfc_host_monitor u_nfc_host_monitor(
    .sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .rdata_valid_out(rdata_valid_out), .flash_ctl_out(flash_ctl_out),
    .flash_io_out(flash_io_out), .flash_io_oe_n_out(flash_io_oe_n_out),
    .flash_ready_in(flash_ready_in));

//--- dv/nfc_flash_model.sv
`timescale 1ns/100ps
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int BUSY_NS = 2000,
    parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
    parameter logic [7:0] PART_ID = 8'hA5 // arbitrary value
) (
    // flash pins
    input wire nfc_ctl_type ctl_in,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic ready_out
);
    // ----------------------------------------
    // behavioural device
    // ----------------------------------------
    logic [7:0] mem [int];
    logic [7:0] pbuf [0:527];
    logic [7:0] cmd;
    logic [9:0] ptr, col;
    logic [15:0] row;
    int acnt;
    event go_busy;
    initial begin
        ready_out = 1'b1;
        io_out = 8'h00;
        ptr = 10'h000;
        cmd = 8'h00;
        acnt = 3;
    end
    always @(go_busy) begin
        ready_out = 1'b0;
        #(BUSY_NS);
        ready_out = 1'b1;
    end
    task automatic do_cmd(input logic [7:0] c);
        cmd = c;
        acnt = 0;
        col = 10'h000;
        case (c)
            CMD_READ_A: ptr = 10'h000;
            CMD_READ_B: ptr = 10'h100;
            CMD_READ_SPARE: ptr = 10'h200;
            CMD_PROG_SETUP: foreach (pbuf[i]) pbuf[i] = 8'hFF;
            CMD_PROG_CONFIRM: begin
                foreach (pbuf[i]) mem[row * PAGE_BYTES + i] = pbuf[i];
                if (ptr == 10'h100) ptr = 10'h000;
                ->go_busy;
            end
            CMD_ERASE_CONFIRM: begin
                for (int k = 0; k < BLOCK_PAGES * PAGE_BYTES; k++)
                    mem.delete(int'(row[15:5]) * BLOCK_PAGES * PAGE_BYTES + k);
                ->go_busy;
            end
            CMD_RESET: begin
                ptr = 10'h000;
                ->go_busy;
            end
            default: ;
        endcase
    endtask
    task automatic do_addr(input logic [7:0] a);
        int idx;
        idx = acnt + (cmd == CMD_ERASE_SETUP ? 1 : 0);
        if (idx < 3) begin
            acnt++;
            if (idx == 0) col = ptr + (ptr == 10'h200 ? a[3:0] : a);
            if (idx == 1) row[7:0] = a;
            if (idx == 2) row[15:8] = a;
            if (idx == 2 && cmd inside {8'h00, 8'h01, 8'h50}) begin
                foreach (pbuf[i]) pbuf[i] = mem.exists(row * PAGE_BYTES + i) ?
                    mem[row * PAGE_BYTES + i] : 8'hFF;
                if (ptr == 10'h100) ptr = 10'h000;
                ->go_busy;
            end
        end
    endtask
    always @(posedge ctl_in.we_n) begin
        if (!ctl_in.ce_n) begin
            if (ctl_in.cle && (ready_out || io_in inside {8'hFF, 8'h70}))
                do_cmd(io_in);
            else if (ctl_in.ale)
                do_addr(io_in);
            else if (!ctl_in.cle && ctl_in.wp_n && col < 528) begin
                pbuf[col] = io_in;
                col++;
            end
        end
    end
    always @(negedge ctl_in.read_strobe_n) begin
        if (cmd == CMD_STATUS) io_out = {ctl_in.wp_n, ready_out, 6'h00};
        else if (cmd == CMD_READ_IDENTIFICATION_CMD) io_out = col == 0 ? MAKER_ID : PART_ID;
        else io_out = col < 528 ? pbuf[col] : 8'hFF;
        col++;
    end
    always @(posedge ctl_in.read_strobe_n) io_out <= #15 ~io_out;
endmodule

//--- dv/tb_nfc_host.sv
`timescale 1ns/100ps
module tb_nfc_host;
    import nfc_pkg::*;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam logic [7:0] ID0 = 8'h3C;
    localparam logic [7:0] ID1 = 8'hA5;
    logic sys_clk_in, reset_in, req_valid_in, req_ready_out, done_out;
    nfc_req_type req_in;
    logic wdata_valid_in, wdata_ready_out, rdata_valid_out;
    logic [7:0] wdata_in, rdata_out, flash_io_out, flash_io_in, model_io;
    nfc_ctl_type flash_ctl_out;
    logic flash_io_oe_n_out, flash_ready_in;
    logic [9:0] wlog[$];
    logic [7:0] rq[$];
    logic [7:0] wpat [0:7] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 0, 0, 0, 0};
    int widx, fails, check_count, cycles;
    assign flash_io_in = flash_io_oe_n_out ? model_io : flash_io_out;
    assign wdata_in = wpat[widx[2:0]];
    nfc_host u_nfc_host(.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .wdata_valid_in(wdata_valid_in),
        .wdata_in(wdata_in), .wdata_ready_out(wdata_ready_out),
        .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out),
        .done_out(done_out), .flash_ctl_out(flash_ctl_out),
        .flash_io_out(flash_io_out), .flash_io_oe_n_out(flash_io_oe_n_out),
        .flash_io_in(flash_io_in), .flash_ready_in(flash_ready_in));
    nfc_flash_model #(.MAKER_ID(ID0), .PART_ID(ID1)) u_nfc_flash_model(
        .ctl_in(flash_ctl_out), .io_in(flash_io_in), .io_out(model_io),
        .ready_out(flash_ready_in));
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge flash_ctl_out.we_n)
        wlog.push_back({flash_ctl_out.cle, flash_ctl_out.ale, flash_io_in});
    always @(posedge sys_clk_in) begin
        if (rdata_valid_out) rq.push_back(rdata_out);
        if (wdata_ready_out) widx <= widx + 1;
        cycles++;
        if (cycles == 60000) begin
            fails++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [9:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic run(input nfc_op_type op, input logic hb,
            input logic [23:0] a, input logic [9:0] n, input logic [9:0] e[$]);
        int t;
        wlog.delete();
        rq.delete();
        @(posedge sys_clk_in);
        req_in <= '{op, hb, a, n};
        req_valid_in <= 1'b1;
        wdata_valid_in <= 1'b1;
        widx <= 0;
        repeat (100) begin
            @(posedge sys_clk_in);
            if (req_ready_out === 1'b1) break;
        end
        req_valid_in <= 1'b0;
        for (t = 0; t < 5000 && done_out !== 1'b1; t++) @(posedge sys_clk_in);
        wdata_valid_in <= 1'b0;
        check("done", t < 5000, 1'b1);
        check("writes", wlog.size(), e.size());
        foreach (e[i])
            if (i < wlog.size()) check("bus", wlog[i], e[i]);
    endtask
    task automatic t_program();
        run(OP_PROGRAM, 0, 24'h01_05_03, 4, '{10'h200, 10'h280, 10'h103,
            10'h105, 10'h101, 10'h0A1, 10'h0B2, 10'h0C3, 10'h0D4,
            10'h210});
        run(OP_READ, 0, 24'h01_05_03, 4, '{10'h200, 10'h103, 10'h105,
            10'h101});
        foreach (rq[i]) check("rd", rq[i], wpat[i]);
        check("rd_count", rq.size(), 4);
    endtask
    task automatic t_half();
        run(OP_PROGRAM, 1, 24'h00_07_02, 2, '{10'h201, 10'h280, 10'h102,
            10'h107, 10'h100, 10'h0A1, 10'h0B2, 10'h210});
        run(OP_READ, 1, 24'h00_07_02, 2, '{10'h201, 10'h102, 10'h107,
            10'h100});
        check("half0", rq[0], 8'hA1);
        run(OP_READ, 0, 24'h00_07_02, 1, '{10'h200, 10'h102, 10'h107,
            10'h100});
        check("revert", rq[0], 8'hFF);
        run(OP_READ_SPARE, 0, 24'h00_07_05, 1, '{10'h250, 10'h105,
            10'h107, 10'h100});
        check("spare", rq[0], 8'hFF);
    endtask
    task automatic t_erase();
        run(OP_ERASE, 0, 24'h01_05_00, 0, '{10'h260, 10'h105, 10'h101,
            10'h2D0});
        run(OP_READ, 0, 24'h01_05_03, 1, '{10'h200, 10'h103, 10'h105,
            10'h101});
        check("erased", rq[0], 8'hFF);
    endtask
    task automatic t_misc();
        run(OP_STATUS, 0, 0, 1, '{10'h270});
        check("status", rq[0], 8'hC0);
        run(OP_READ_IDENTIFICATION_CMD, 0, 0, 2, '{10'h290});
        check("id0", rq[0], ID0);
        check("id1", rq[1], ID1);
        run(OP_RESET, 0, 0, 0, '{10'h2FF});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        reset_in = 1'b1;
        req_valid_in = 1'b0;
        req_in = '0;
        wdata_valid_in = 1'b0;
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        t_program();
        t_half();
        t_erase();
        t_misc();
        summarize();
    end
endmodule
